/* File: core/bfs_params.svh */
// Contract
// - Current mode: times on phase or residual pickup.
// - Current mode: output after full delay elapses.
// - Current mode: timer clears when currents drop.
// - Current-and-trip: timer halted until trip present.
// - Current-and-trip: times while trip, output after delay.
// - Current-and-trip: clears on current drop or trip release.
// - Current-or-trip: starts on pickup or trip.
// - Current-or-trip: output if either persists full delay.
// - Current-or-trip: clears only when both released.
// - Input mode: digital input times the output.
// - Input mode: own trip used only for failure.
// - ON/OFF events for eight sources, selectable storing.
// - Every event carries a time stamp.
// - Resettable counters for four occurrence kinds.
// - Rolling log of latest twelve ON entries.
// - Log entry holds stamp, name, currents, remaining times.
// - Blocking at pickup flags blocked, drops start.
// - One timer on shared pickup serves both delays, 5 ms steps.
`ifndef BFS_PARAMS_SVH
`define BFS_PARAMS_SVH
`define BFS_CLK_PERIOD_NS 8
`define BFS_STEP_NS       5000000
`define BFS_STEP_CYC      ((`BFS_STEP_NS + `BFS_CLK_PERIOD_NS - 1) / `BFS_CLK_PERIOD_NS)
`define BFS_LOG_DEPTH     12
`define BFS_EV_START      0
`define BFS_EV_RETRIP     1
`define BFS_EV_FAIL       2
`define BFS_EV_BLOCK      3
`define BFS_EV_TRIPMON    4
`define BFS_EV_DIN        5
`define BFS_EV_PHASE      6
`define BFS_EV_RES        7
`define BFS_EV_NUM        8
`endif

/* File: core/bfs_pkg.sv */
package bfs_pkg;
  typedef enum logic [1:0] {
    BFS_CRIT_CUR     = 2'h0,
    BFS_CRIT_CUR_AND = 2'h1,
    BFS_CRIT_CUR_OR  = 2'h2,
    BFS_CRIT_DIN     = 2'h3
  } bfs_crit_t;
  typedef enum logic [4:0] {
    BFS_NORMAL  = 5'h01,
    BFS_START   = 5'h02,
    BFS_RETRIP  = 5'h04,
    BFS_FAIL_ON = 5'h08,
    BFS_BLOCKED = 5'h10
  } bfs_cond_t;
  typedef struct packed {
    logic [2:0]  code;
    logic        is_on;
    logic [47:0] stamp;
  } bfs_event_t;
  typedef struct packed {
    logic [47:0] stamp;
    logic [2:0]  code;
    logic [15:0] phase_max;
    logic [15:0] residual;
    logic [15:0] to_retrip;
    logic [15:0] to_fail;
    logic [2:0]  set_group;
  } bfs_log_t;
endpackage

/* File: core/bfs_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bfs_params.svh"
module bfs_supervisor #(
  parameter int STEP_CYC = `BFS_STEP_CYC,
  parameter int DW       = 16,
  parameter int CNT_W    = 16
) (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // Settings
  input  wire bfs_pkg::bfs_crit_t   i_crit,
  input  wire logic                 i_retrip_en,
  input  wire logic [DW-1:0]        i_redundant_trip_delay,
  input  wire logic [DW-1:0]        i_fail_delay,
  input  wire logic [15:0]          i_phase_current_threshold,
  input  wire logic [15:0]          i_residual_current_threshold,
  input  wire logic                 i_res_sel_two,
  input  wire logic                 i_store_on,
  input  wire logic                 i_store_off,
  input  wire logic [2:0]           i_set_group,
  // Process inputs
  input  wire logic [15:0]          i_phase_max,
  input  wire logic [15:0]          i_residual_input_one,
  input  wire logic [15:0]          i_residual_input_two,
  input  wire logic                 i_trip_mon,
  input  wire logic                 i_din,
  input  wire logic                 i_block,
  input  wire logic [47:0]          i_time,
  // Counter and log access
  input  wire logic                 i_cnt_clr,
  input  wire logic [3:0]           i_log_idx,
  // Protection outputs
  output logic                      o_start,
  output logic                      o_retrip,
  output logic                      o_breaker_failure_output,
  output logic                      o_blocked,
  output logic                      o_dev_trip,
  output bfs_pkg::bfs_cond_t        o_cond,
  // Events
  output logic                      o_evt_valid,
  output bfs_pkg::bfs_event_t       o_failure_event_group,
  // Counters and log
  output logic [CNT_W-1:0]          o_cnt_retrip,
  output logic [CNT_W-1:0]          o_cnt_fail,
  output logic [CNT_W-1:0]          o_cnt_start,
  output logic [CNT_W-1:0]          o_cnt_blocked,
  output logic [3:0]                o_log_count,
  output bfs_pkg::bfs_log_t         o_log_entry
);
  localparam int SW = (STEP_CYC > 1) ? $clog2(STEP_CYC) : 1;
  localparam int EN = `BFS_EV_NUM;
  localparam logic [3:0] LOG_LAST = 4'(`BFS_LOG_DEPTH - 1);

  function automatic logic [DW-1:0] sat_sub(input logic [DW-1:0] a, input logic [DW-1:0] b);
    sat_sub = (a > b) ? a - b : '0;
  endfunction

  function automatic logic [CNT_W-1:0] cnt_next(input logic [CNT_W-1:0] c, input logic inc,
                                                input logic clr);
    logic [CNT_W-1:0] base;
    base = clr ? '0 : c;
    // A simultaneous clear applies first, then the increment counts from zero
    cnt_next = (inc && base != '1) ? base + 1'b1 : base;
  endfunction

  function automatic logic [4:0] first_set(input logic [2*EN-1:0] v);
    first_set = '0;
    for (int k = 2*EN-1; k >= 0; k--) begin
      if (v[k]) begin
        first_set = {1'b1, 4'(k)};
      end
    end
  endfunction

  // Pickup and mode selection
  logic [15:0] res_c;
  logic        ph_pu_c;
  logic        res_pu_c;
  logic        cur_c;
  logic        run_c;
  logic        start_c;
  logic        blk_c;
  logic        retrip_c;
  logic        fail_c;

  assign res_c    = i_res_sel_two ? i_residual_input_two : i_residual_input_one;
  assign ph_pu_c  = i_phase_max > i_phase_current_threshold;
  assign res_pu_c = res_c > i_residual_current_threshold;
  assign cur_c    = ph_pu_c | res_pu_c;

  always_comb begin
    case (i_crit)
      bfs_pkg::BFS_CRIT_CUR:     run_c = cur_c;
      bfs_pkg::BFS_CRIT_CUR_AND: run_c = cur_c & i_trip_mon;
      bfs_pkg::BFS_CRIT_CUR_OR:  run_c = cur_c | i_trip_mon;
      bfs_pkg::BFS_CRIT_DIN:     run_c = i_din;
      default:                   run_c = 1'b0;
    endcase
  end

  // Block is sampled every cycle, so a late block also drops an active start
  assign blk_c   = run_c & i_block;
  assign start_c = run_c & ~i_block;

  // Common step timer
  logic [SW-1:0] step_cnt_ff;
  logic          step_ff;
  logic [DW-1:0] tmr_ff;

  always_ff @(posedge i_clk) begin
    if (i_rst || step_cnt_ff == SW'(STEP_CYC - 1)) begin
      step_cnt_ff <= '0;
    end else begin
      step_cnt_ff <= step_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      step_ff <= 1'b0;
    end else begin
      step_ff <= (step_cnt_ff == SW'(STEP_CYC - 1));
    end
  end

  // One count serves both delays; cleared the moment pickup releases
  always_ff @(posedge i_clk) begin
    if (i_rst || !start_c) begin
      tmr_ff <= '0;
    end else if (step_ff && tmr_ff != '1) begin
      tmr_ff <= tmr_ff + 1'b1;
    end
  end

  assign retrip_c = start_c & i_retrip_en & (tmr_ff >= i_redundant_trip_delay);
  assign fail_c   = start_c & (tmr_ff >= i_fail_delay);

  // Registered protection outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_start                  <= 1'b0;
      o_retrip                 <= 1'b0;
      o_breaker_failure_output <= 1'b0;
      o_blocked                <= 1'b0;
      o_dev_trip               <= 1'b0;
    end else begin
      o_start                  <= start_c;
      o_retrip                 <= retrip_c;
      o_breaker_failure_output <= fail_c;
      o_blocked                <= blk_c;
      // Dedicated unit reuses its own trip contact for failure only
      o_dev_trip <= (i_crit == bfs_pkg::BFS_CRIT_DIN) ? fail_c : i_trip_mon;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cond <= bfs_pkg::BFS_NORMAL;
    end else if (blk_c) begin
      o_cond <= bfs_pkg::BFS_BLOCKED;
    end else if (fail_c) begin
      o_cond <= bfs_pkg::BFS_FAIL_ON;
    end else if (retrip_c) begin
      o_cond <= bfs_pkg::BFS_RETRIP;
    end else if (start_c) begin
      o_cond <= bfs_pkg::BFS_START;
    end else begin
      o_cond <= bfs_pkg::BFS_NORMAL;
    end
  end

  // Event detection; pending bits keep simultaneous edges from being lost
  logic [EN-1:0]   src_c;
  logic [EN-1:0]   src_prev_ff;
  logic [2*EN-1:0] pend_ff;
  logic [2*EN-1:0] edge_c;
  logic [2*EN-1:0] take_c;
  logic [4:0]      pick_c;

  always_comb begin
    src_c = '0;
    src_c[`BFS_EV_START]   = start_c;
    src_c[`BFS_EV_RETRIP]  = retrip_c;
    src_c[`BFS_EV_FAIL]    = fail_c;
    src_c[`BFS_EV_BLOCK]   = i_block;
    src_c[`BFS_EV_TRIPMON] = i_trip_mon;
    src_c[`BFS_EV_DIN]     = i_din;
    src_c[`BFS_EV_PHASE]   = ph_pu_c;
    src_c[`BFS_EV_RES]     = res_pu_c;
  end

  assign edge_c = {(src_prev_ff & ~src_c) & {EN{i_store_off}},
                   (src_c & ~src_prev_ff) & {EN{i_store_on}}};
  assign pick_c = first_set(pend_ff);

  always_comb begin
    take_c = '0;
    if (pick_c[4]) begin
      take_c[pick_c[3:0]] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      src_prev_ff <= '0;
      pend_ff     <= '0;
    end else begin
      src_prev_ff <= src_c;
      pend_ff     <= (pend_ff & ~take_c) | edge_c;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_evt_valid           <= 1'b0;
      o_failure_event_group <= '0;
    end else begin
      o_evt_valid                 <= pick_c[4];
      o_failure_event_group.code  <= pick_c[2:0];
      o_failure_event_group.is_on <= ~pick_c[3];
      o_failure_event_group.stamp <= i_time;
    end
  end

  // Cumulative counters
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cnt_retrip  <= '0;
      o_cnt_fail    <= '0;
      o_cnt_start   <= '0;
      o_cnt_blocked <= '0;
    end else begin
      o_cnt_retrip  <= cnt_next(o_cnt_retrip, retrip_c & ~o_retrip, i_cnt_clr);
      o_cnt_fail    <= cnt_next(o_cnt_fail, fail_c & ~o_breaker_failure_output, i_cnt_clr);
      o_cnt_start   <= cnt_next(o_cnt_start, start_c & ~o_start, i_cnt_clr);
      o_cnt_blocked <= cnt_next(o_cnt_blocked, blk_c & ~o_blocked, i_cnt_clr);
    end
  end

  // Rolling log of ON events
  bfs_pkg::bfs_log_t log_mem [`BFS_LOG_DEPTH];
  logic [3:0]        log_wr_ff;
  logic              log_we_c;

  assign log_we_c = pick_c[4] & ~pick_c[3];

  always_ff @(posedge i_clk) begin
    if (log_we_c) begin
      log_mem[log_wr_ff] <= '{stamp:     i_time,
                              code:      pick_c[2:0],
                              phase_max: i_phase_max,
                              residual:  res_c,
                              to_retrip: sat_sub(i_redundant_trip_delay, tmr_ff),
                              to_fail:   sat_sub(i_fail_delay, tmr_ff),
                              set_group: i_set_group};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      log_wr_ff   <= '0;
      o_log_count <= '0;
    end else if (log_we_c) begin
      log_wr_ff   <= (log_wr_ff == LOG_LAST) ? '0 : log_wr_ff + 1'b1;
      o_log_count <= (o_log_count > LOG_LAST) ? o_log_count : o_log_count + 1'b1;
    end
  end

  // Unwritten slots read back as zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_log_entry <= '0;
    end else if (i_log_idx < o_log_count) begin
      o_log_entry <= log_mem[i_log_idx];
    end else begin
      o_log_entry <= '0;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_cur_pickup_start: assert property ((i_crit == bfs_pkg::BFS_CRIT_CUR) && cur_c && !i_block
    |=> o_start) else $error("current pickup did not start");
  a_release_clears: assert property (!start_c |=> (tmr_ff == '0) && !o_breaker_failure_output)
    else $error("timer not cleared on release");
  a_and_halted: assert property ((i_crit == bfs_pkg::BFS_CRIT_CUR_AND) && !i_trip_mon
    |=> tmr_ff == '0 && !o_start) else $error("timer ran without trip");
  a_and_reset: assert property ((i_crit == bfs_pkg::BFS_CRIT_CUR_AND) && (!cur_c || !i_trip_mon)
    |=> !o_breaker_failure_output) else $error("failure kept after release");
  a_or_hold: assert property ((i_crit == bfs_pkg::BFS_CRIT_CUR_OR) && (cur_c || i_trip_mon)
    && !i_block |=> o_start) else $error("or mode start missing");
  a_fail_delay: assert property (start_c && (tmr_ff >= i_fail_delay)
    |=> o_breaker_failure_output) else $error("failure not raised after delay");
  a_fail_cause: assert property ($rose(o_breaker_failure_output)
    |-> $past(start_c) && ($past(tmr_ff) >= $past(i_fail_delay)))
    else $error("failure raised early");
  a_din_trip: assert property ((i_crit == bfs_pkg::BFS_CRIT_DIN)
    |=> o_dev_trip == o_breaker_failure_output) else $error("own trip not failure");
  a_block_flag: assert property (run_c && i_block |=> o_blocked && !o_start)
    else $error("block not flagged");
  a_step_count: assert property (step_ff && start_c && tmr_ff != '1 && $past(start_c)
    |=> tmr_ff == $past(tmr_ff) + 1'b1) else $error("timer missed a tick");
  a_evt_stamp: assert property (pick_c[4] |=> o_evt_valid
    && o_failure_event_group.stamp == $past(i_time)) else $error("event stamp wrong");
  a_log_bound: assert property (log_we_c && o_log_count == 4'(`BFS_LOG_DEPTH)
    |=> o_log_count == 4'(`BFS_LOG_DEPTH)) else $error("log count overran");

  c_fail_cur: cover property ((i_crit == bfs_pkg::BFS_CRIT_CUR) && $rose(o_breaker_failure_output));
  c_fail_din: cover property ((i_crit == bfs_pkg::BFS_CRIT_DIN) && $rose(o_breaker_failure_output));
  c_block_start: cover property (o_start ##1 o_blocked);
  c_log_wrap: cover property (log_we_c && log_wr_ff == LOG_LAST);
endmodule
`default_nettype wire

/* File: dv/bfs_breaker_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Primary stage and its trip contact, plus the digital input wiring
module bfs_breaker_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Scenario control
  input  wire logic       i_fault,
  input  wire logic       i_din_cmd,
  input  wire logic [3:0] i_lag,
  // Contacts toward the supervisor
  output logic            o_trip_mon,
  output logic            o_din
);
  logic [3:0] age_ff;

  // Primary stage operates a few cycles after the fault, releases at once
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_fault) begin
      age_ff     <= 4'h0;
      o_trip_mon <= 1'b0;
    end else begin
      if (age_ff != i_lag) begin
        age_ff <= age_ff + 4'h1;
      end
      o_trip_mon <= (age_ff == i_lag);
    end
  end

  always_ff @(posedge i_clk) begin
    o_din <= !i_rst && i_din_cmd;
  end
endmodule
`default_nettype wire

/* File: dv/test_breaker_failure_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
module test_breaker_failure_supervisor;
  localparam int S = 4;
  logic i_clk, i_rst, i_retrip_en, i_res_sel_two, i_store_on, i_store_off;
  logic i_block, i_cnt_clr, i_fault, i_din_cmd, i_trip_mon, i_din;
  bfs_pkg::bfs_crit_t i_crit;
  logic [15:0] i_redundant_trip_delay, i_fail_delay, i_phase_current_threshold;
  logic [15:0] i_residual_current_threshold, i_phase_max;
  logic [15:0] i_residual_input_one, i_residual_input_two;
  logic [2:0] i_set_group;
  logic [3:0] i_log_idx, i_lag, o_log_count;
  logic [47:0] i_time;
  logic o_start, o_retrip, o_breaker_failure_output, o_blocked, o_dev_trip, o_evt_valid;
  bfs_pkg::bfs_cond_t o_cond;
  bfs_pkg::bfs_event_t o_failure_event_group;
  bfs_pkg::bfs_log_t o_log_entry;
  logic [15:0] o_cnt_retrip, o_cnt_fail, o_cnt_start, o_cnt_blocked;
  bfs_pkg::bfs_event_t evq[$];
  int bad_count, check_count, n, d;
  logic [7:0] m;
  logic on_only, inc;

  bfs_supervisor #(.STEP_CYC(S)) dut (.i_clk, .i_rst, .i_crit, .i_retrip_en,
    .i_redundant_trip_delay, .i_fail_delay, .i_phase_current_threshold,
    .i_residual_current_threshold, .i_res_sel_two, .i_store_on, .i_store_off,
    .i_set_group, .i_phase_max, .i_residual_input_one, .i_residual_input_two,
    .i_trip_mon, .i_din, .i_block, .i_time, .i_cnt_clr, .i_log_idx, .o_start,
    .o_retrip, .o_breaker_failure_output, .o_blocked, .o_dev_trip, .o_cond,
    .o_evt_valid, .o_failure_event_group, .o_cnt_retrip, .o_cnt_fail, .o_cnt_start,
    .o_cnt_blocked, .o_log_count, .o_log_entry);

  bfs_breaker_model far (.i_clk, .i_rst, .i_fault, .i_din_cmd, .i_lag,
    .o_trip_mon(i_trip_mon), .o_din(i_din));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  always @(posedge i_clk) i_time <= i_time + 48'h1;
  always @(posedge i_clk) if (o_evt_valid === 1'b1) evq.push_back(o_failure_event_group);

  task summarize();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wt(input int k);
    repeat (k) @(posedge i_clk);
  endtask

  // Boundary values: exactly at threshold must not pick up
  task cur(input logic ph, input logic rs);
    i_phase_max <= ph ? i_phase_current_threshold + 16'h1 : i_phase_current_threshold;
    i_residual_input_one <= rs ? i_residual_current_threshold + 16'h1
                               : i_residual_current_threshold;
    // Second channel inverted, so a wrong select picks up where it must not
    i_residual_input_two <= rs ? i_residual_current_threshold : 16'hffff;
  endtask

  // Step divider phase is free, so only a window of one step is exact
  task tfail(input int lo, input int hi);
    n = 0;
    while (o_breaker_failure_output !== 1'b1 && n < 300) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk("fail_time", 48'(n >= lo && n <= hi), 48'h1);
  endtask

  initial begin
    #(8 * 6000);
    bad_count++;
    summarize();
  end

  initial begin
    void'($urandom(32'h3ca07316));
    {i_rst, i_retrip_en, i_store_on} = 3'h7;
    {i_res_sel_two, i_store_off, i_block, i_cnt_clr, i_fault, i_din_cmd} = 6'h00;
    i_crit = bfs_pkg::BFS_CRIT_CUR;
    i_redundant_trip_delay = 16'h1;
    i_fail_delay = 16'h2;
    i_phase_current_threshold = 16'h0100 + 16'($urandom % 256);
    i_residual_current_threshold = 16'h0040 + 16'($urandom % 64);
    i_phase_max = 16'h0;
    i_residual_input_one = 16'h0;
    i_residual_input_two = 16'h0;
    i_set_group = 3'h0;
    i_log_idx = 4'h0;
    i_lag = 4'h0;
    i_time = 48'h0;
    wt(10);
    i_rst <= 1'b0;
    for (int r = 0; r < 3; r++) begin
      d = 2 + $urandom % 4;
      wt(1);
      i_fail_delay <= 16'(d);
      i_res_sel_two <= (r == 2);
      cur(r == 0, r == 1);
      tfail((d - 1) * S + 1, d * S + 3);
      chk("start", o_start, 1);
      chk("cond", o_cond, bfs_pkg::BFS_FAIL_ON);
      wt(1);
      cur(0, r == 2);
      wt(1);
      #1 chk("drop", {o_start, o_breaker_failure_output}, 0);
    end
    wt(1);
    i_res_sel_two <= 1'b0;
    i_crit <= bfs_pkg::BFS_CRIT_CUR_AND;
    i_lag <= 4'($urandom % 4);
    cur(1, 0);
    wt(4 * S * d);
    #1 chk("halted", {o_start, o_breaker_failure_output}, 0);
    wt(1);
    i_fault <= 1'b1;
    tfail((d - 1) * S + 1, d * S + 8);
    chk("retrip", o_retrip, 1);
    chk("dev_follow", o_dev_trip, 1);
    wt(1);
    i_fault <= 1'b0;
    wt(3);
    #1 chk("trip_rel", o_breaker_failure_output, 0);
    wt(1);
    i_crit <= bfs_pkg::BFS_CRIT_CUR_OR;
    cur(0, 0);
    i_fault <= 1'b1;
    tfail((d - 1) * S + 1, d * S + 8);
    wt(1);
    cur(1, 0);
    i_fault <= 1'b0;
    wt(4);
    #1 chk("either", o_breaker_failure_output, 1);
    wt(1);
    cur(0, 0);
    wt(1);
    #1 chk("both_rel", o_breaker_failure_output, 0);
    wt(1);
    i_crit <= bfs_pkg::BFS_CRIT_DIN;
    cur(1, 1);
    wt(4 * S * d);
    #1 chk("din_idle", o_breaker_failure_output, 0);
    wt(1);
    i_din_cmd <= 1'b1;
    tfail((d - 1) * S + 1, d * S + 5);
    chk("dev_trip", o_dev_trip, 1);
    wt(1);
    i_din_cmd <= 1'b0;
    wt(3);
    #1 chk("din_rel", {o_breaker_failure_output, o_dev_trip}, 0);
    wt(1);
    i_crit <= bfs_pkg::BFS_CRIT_CUR;
    cur(0, 0);
    i_block <= 1'b1;
    wt(1);
    cur(1, 0);
    wt(2);
    #1 chk("blocked", {o_blocked, o_start, o_cond}, {2'b10, bfs_pkg::BFS_BLOCKED});
    wt(1);
    i_block <= 1'b0;
    cur(0, 0);
    wt(2);
    cur(1, 0);
    wt(2);
    chk("start_up", o_start, 1);
    i_block <= 1'b1;
    wt(2);
    #1 chk("start_drop", o_start, 0);
    wt(1);
    i_block <= 1'b0;
    cur(0, 0);
    wt(20);
    {m, on_only, inc} = 10'h003;
    foreach (evq[i]) begin
      m[evq[i].code] = 1'b1;
      on_only &= evq[i].is_on;
      if (i > 0 && evq[i].stamp <= evq[i - 1].stamp) inc = 1'b0;
    end
    chk("ev_codes", m, 8'hff);
    chk("ev_on_only", on_only, 1);
    chk("ev_stamps", inc, 1);
    chk("log_full", o_log_count, 12);
    chk("cnt_fail", o_cnt_fail, 6);
    chk("cnt_blocked", o_cnt_blocked, 2);
    // Second reset in mid-run, then a single start with no failure
    wt(1);
    i_rst <= 1'b1;
    i_retrip_en <= 1'b0;
    i_fail_delay <= 16'h0040;
    wt(2);
    i_rst <= 1'b0;
    i_set_group <= 3'($urandom);
    cur(1, 0);
    wt(12);
    #1 chk("log_two", o_log_count, 2);
    chk("cnt_start", o_cnt_start, 1);
    for (int s = 0; s < 2; s++) begin
      wt(1);
      i_log_idx <= 4'(s);
      wt(2);
      #1 chk("log_code", o_log_entry.code, s ? 6 : 0);
      chk("log_data", {o_log_entry.phase_max, o_log_entry.residual, o_log_entry.set_group},
          {i_phase_max, i_residual_current_threshold, i_set_group});
      chk("log_left", {o_log_entry.to_retrip, o_log_entry.to_fail}, 32'h0001_0040);
    end
    wt(1);
    i_cnt_clr <= 1'b1;
    wt(1);
    i_cnt_clr <= 1'b0;
    wt(1);
    #1 chk("cnt_clr", {o_cnt_retrip, o_cnt_fail, o_cnt_start, o_cnt_blocked}, 0);
    wt(1);
    i_store_on <= 1'b0;
    i_store_off <= 1'b1;
    evq.delete();
    cur(0, 0);
    wt(8);
    #1 chk("off_evt", {evq.size() > 0, evq[0].is_on}, 2'b10);
    summarize();
  end
endmodule
`default_nettype wire
